// ==== core/supply_status_trigger_io.sv ====
// Purpose: status flags, trigger input actions and trigger output of a supply
// Assumes: supply state and trips come from logic on clk_i; trigger pin is async
// Notes:   registers on a plain strobe port, read data one cycle after the strobe
`default_nettype none
// Notes on behaviour
// - cv flag low while regulating constant voltage with output enabled
// - cc flag low while regulating constant current with output enabled
// - alarm flag low when any protection trips
// - alarm, power and output flags are active low
// - output-on flag low while output enabled
// - trigger performs one configured action
// - trigger accepted only at or above configured pulse width
// - trigger output fires on selected events
// - trigger output pulses or holds configured level
// - trigger output rests high when idle
module supply_status_trigger_io
  import supply_io_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire supply_state_t       supply_i,
  input  wire logic                setting_changed_i,
  input  wire logic                trigger_input_n_i,
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic [DATA_W-1:0]   reg_wdata_i,
  input  wire logic                reg_write_i,
  input  wire logic                reg_read_i,
  output logic [DATA_W-1:0]        reg_rdata_o,
  output logic                     output_enable_o,
  output trig_cmd_t                trig_cmd_o,
  output logic                     const_voltage_flag_n_o,
  output logic                     const_current_flag_n_o,
  output logic                     protection_alarm_flag_n_o,
  output logic                     powered_flag_n_o,
  output logic                     output_on_flag_n_o,
  output logic                     trigger_output_o,
  output logic                     irq_o
);
  typedef struct packed {
    logic               out_en;
    logic [1:0]         act;
    logic [3:0]         slot;
    logic [WIDTH_W-1:0] in_width;
    logic [2:0]         ev_sel;
    logic               lvl_mode;
    logic               lvl_pol;
    logic [WIDTH_W-1:0] out_width;
    logic [IRQ_W-1:0]   irq_stat;
    logic [IRQ_W-1:0]   irq_mask;
    logic [DATA_W-1:0]  rdata;
    logic               alarm_q;
    logic               cv_n;
    logic               cc_n;
    logic               alm_n;
    logic               pwr_n;
    logic               on_n;
    trig_cmd_t          cmd;
  } core_t;

  core_t        st_q, st_d;
  reg_req_t     req;
  logic         accept;
  logic         alarm;
  logic         out_event;
  logic         cfg_out_wr;
  trig_action_t action;
  logic [IRQ_W-1:0] irq_set;

  assign req = '{write: reg_write_i, read: reg_read_i, addr: reg_addr_i, wdata: reg_wdata_i};
  assign action = trig_action_t'(st_q.act);
  assign alarm = |supply_i.trips;
  assign cfg_out_wr = req.write && (req.addr == OFS_TRIGGER_OUTPUT);

  trigger_input_filter u_trigger_input (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_n_i (trigger_input_n_i),
    .width_i (st_q.in_width),
    .accept_o(accept)
  );

  // output on/off, setting changes and recalls, gated by the select mask
  assign out_event = (st_q.ev_sel[SEL_ONOFF] && (st_d.out_en != st_q.out_en))
                   || (st_q.ev_sel[SEL_SETTING]
                       && (setting_changed_i || st_q.cmd.apply_v || st_q.cmd.apply_c))
                   || (st_q.ev_sel[SEL_RECALL] && st_q.cmd.recall);

  trigger_output_gen u_trigger_output (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .event_i     (out_event),
    .level_mode_i(st_q.lvl_mode),
    .level_pol_i (st_q.lvl_pol),
    .width_i     (st_q.out_width),
    .release_i   (cfg_out_wr),
    .trig_o      (trigger_output_o)
  );

  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.cmd.recall = 1'b0;
    st_d.cmd.apply_v = 1'b0;
    st_d.cmd.apply_c = 1'b0;
    irq_set = '0;

    // register writes
    if (req.write) begin
      if (req.addr == OFS_CTRL) begin
        st_d.out_en = req.wdata[0];
      end else if (req.addr == OFS_TRIGGER_INPUT) begin
        st_d.act = req.wdata[TI_ACT_LSB +: 2];
        st_d.slot = req.wdata[TI_SLOT_LSB +: 4];
        st_d.in_width = req.wdata[TI_WIDTH_LSB +: WIDTH_W];
      end else if (req.addr == OFS_TRIGGER_OUTPUT) begin
        st_d.ev_sel = req.wdata[TO_SEL_LSB +: 3];
        st_d.lvl_mode = req.wdata[TO_LVL_BIT];
        st_d.lvl_pol = req.wdata[TO_POL_BIT];
        st_d.out_width = req.wdata[TO_WIDTH_LSB +: WIDTH_W];
      end else if (req.addr == OFS_IRQ_STAT) begin
        st_d.irq_stat = st_q.irq_stat & ~req.wdata[IRQ_W-1:0];
      end else if (req.addr == OFS_IRQ_MASK) begin
        st_d.irq_mask = req.wdata[IRQ_W-1:0];
      end
    end

    // one action per accepted trigger; trigger wins over a same-cycle write
    if (accept) begin
      case (action)
        ACT_TOGGLE:  st_d.out_en = !st_q.out_en;
        ACT_RECALL:  st_d.cmd.recall = 1'b1;
        ACT_APPLY_V: st_d.cmd.apply_v = 1'b1;
        default:     st_d.cmd.apply_c = 1'b1;
      endcase
      st_d.cmd.slot = st_q.slot;
    end

    // status flags, all active low
    st_d.cv_n = !(supply_i.cv_reg && st_q.out_en);
    st_d.cc_n = !(supply_i.cc_reg && st_q.out_en);
    st_d.alm_n = !alarm;
    st_d.pwr_n = !supply_i.powered;
    st_d.on_n = !st_q.out_en;

    // sticky events; set beats a same-cycle clear
    st_d.alarm_q = alarm;
    irq_set[IRQ_TRIGGER_INPUT] = accept;
    irq_set[IRQ_TRIGGER_OUTPUT] = out_event;
    irq_set[IRQ_ALARM] = alarm && !st_q.alarm_q;
    st_d.irq_stat = st_d.irq_stat | irq_set;

    // register reads, unmapped reads return zero
    if (req.read) begin
      if (req.addr == OFS_CTRL) begin
        st_d.rdata = DATA_W'(st_q.out_en);
      end else if (req.addr == OFS_TRIGGER_INPUT) begin
        st_d.rdata = {st_q.in_width, 8'h00, st_q.slot, 2'b00, st_q.act};
      end else if (req.addr == OFS_TRIGGER_OUTPUT) begin
        st_d.rdata = {st_q.out_width, 11'h000, st_q.lvl_pol, st_q.lvl_mode, st_q.ev_sel};
      end else if (req.addr == OFS_STATE) begin
        st_d.rdata = {16'h0000, 1'b0, trigger_output_o, st_q.alarm_q, supply_i.powered,
                      3'h0, supply_i.trips};
      end else if (req.addr == OFS_IRQ_STAT) begin
        st_d.rdata = DATA_W'(st_q.irq_stat);
      end else if (req.addr == OFS_IRQ_MASK) begin
        st_d.rdata = DATA_W'(st_q.irq_mask);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= '{out_en: 1'b0, act: 2'b00, slot: 4'h0, in_width: RST_IN_WIDTH,
                ev_sel: RST_EV_SEL, lvl_mode: 1'b0, lvl_pol: 1'b0,
                out_width: RST_OUT_WIDTH, irq_stat: '0, irq_mask: '0, rdata: '0,
                alarm_q: 1'b0, cv_n: 1'b1, cc_n: 1'b1, alm_n: 1'b1, pwr_n: 1'b1,
                on_n: 1'b1, cmd: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign output_enable_o = st_q.out_en;
  assign trig_cmd_o = st_q.cmd;
  assign const_voltage_flag_n_o = st_q.cv_n;
  assign const_current_flag_n_o = st_q.cc_n;
  assign protection_alarm_flag_n_o = st_q.alm_n;
  assign powered_flag_n_o = st_q.pwr_n;
  assign output_on_flag_n_o = st_q.on_n;
  assign irq_o = |(st_q.irq_stat & st_q.irq_mask);

  sequence accept_toggle_s;
    accept && action == ACT_TOGGLE && !req.write;
  endsequence

  AST_CV_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (supply_i.cv_reg && st_q.out_en) |=> !const_voltage_flag_n_o)
    else $error("cv flag not low in cv regulation");
  AST_CC_FLAG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (supply_i.cc_reg && st_q.out_en) |=> !const_current_flag_n_o)
    else $error("cc flag not low in cc regulation");
  AST_ALARM: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    alarm |=> !protection_alarm_flag_n_o)
    else $error("alarm flag not low on trip");
  AST_POWERED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    supply_i.powered |=> !powered_flag_n_o)
    else $error("power flag not low while powered");
  AST_OUT_ON: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 (output_on_flag_n_o == !$past(output_enable_o)))
    else $error("output-on flag disagrees with output enable");
  AST_TOGGLE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept_toggle_s |=> output_enable_o != $past(output_enable_o) ##1 !output_on_flag_n_o
      == output_enable_o)
    else $error("toggle trigger did not flip output");
  AST_ONOFF_EVENT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_q.ev_sel[SEL_ONOFF] && st_d.out_en != st_q.out_en && !st_q.lvl_mode) |=> ##1
      !trigger_output_o)
    else $error("on/off event did not pulse trigger output");
  AST_REST_HIGH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!out_event && !st_q.lvl_mode && u_trigger_output.st_q.cnt == '0) [*2] |=> trigger_output_o)
    else $error("trigger output not resting high");
  AST_MODE_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !output_enable_o [*2] |-> const_voltage_flag_n_o && const_current_flag_n_o)
    else $error("mode flag low while output disabled");
endmodule
`default_nettype wire

// ==== core/supply_io_pkg.sv ====
// Purpose: shared constants and types of the supply status and trigger block
// Assumes: 32-bit register port, word addresses as byte offsets
// Notes:   write field positions and three reset values live here; read layouts are coded in the module
`default_nettype none
package supply_io_pkg;
  localparam int unsigned   DATA_W          = 32;
  localparam int unsigned   ADDR_W          = 8;
  localparam int unsigned   TRIP_W          = 9;
  localparam int unsigned   WIDTH_W         = 16;
  localparam int unsigned   IRQ_W           = 3;

  localparam logic [7:0]    OFS_CTRL        = 8'h00;
  localparam logic [7:0]    OFS_TRIGGER_INPUT     = 8'h04;
  localparam logic [7:0]    OFS_TRIGGER_OUTPUT    = 8'h08;
  localparam logic [7:0]    OFS_STATE       = 8'h0c;
  localparam logic [7:0]    OFS_IRQ_STAT    = 8'h10;
  localparam logic [7:0]    OFS_IRQ_MASK    = 8'h14;

  // trigger input config fields
  localparam int unsigned   TI_ACT_LSB      = 0;
  localparam int unsigned   TI_SLOT_LSB     = 4;
  localparam int unsigned   TI_WIDTH_LSB    = 16;
  // trigger output config fields
  localparam int unsigned   TO_SEL_LSB      = 0;
  localparam int unsigned   TO_LVL_BIT      = 3;
  localparam int unsigned   TO_POL_BIT      = 4;
  localparam int unsigned   TO_WIDTH_LSB    = 16;
  // event select bits
  localparam int unsigned   SEL_ONOFF       = 0;
  localparam int unsigned   SEL_SETTING     = 1;
  localparam int unsigned   SEL_RECALL      = 2;
  // interrupt bits
  localparam int unsigned   IRQ_TRIGGER_INPUT     = 0;
  localparam int unsigned   IRQ_TRIGGER_OUTPUT    = 1;
  localparam int unsigned   IRQ_ALARM       = 2;

  localparam logic [WIDTH_W-1:0] RST_IN_WIDTH  = 16'h0064;
  localparam logic [WIDTH_W-1:0] RST_OUT_WIDTH = 16'h0064;
  localparam logic [2:0]         RST_EV_SEL    = 3'h1;

  typedef enum logic [1:0] {
    ACT_TOGGLE,
    ACT_RECALL,
    ACT_APPLY_V,
    ACT_APPLY_C
  } trig_action_t;

  typedef struct packed {
    logic              cv_reg;
    logic              cc_reg;
    logic              powered;
    logic [TRIP_W-1:0] trips;
  } supply_state_t;

  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       recall;
    logic       apply_v;
    logic       apply_c;
    logic [3:0] slot;
  } trig_cmd_t;
endpackage
`default_nettype wire

// ==== core/trigger_input_filter.sv ====
// Purpose: synchronise the trigger pin and accept pulses of a least width
// Assumes: pin is active low and asynchronous to clk_i
// Notes:   one accept pulse per qualifying low pulse
`default_nettype none
module trigger_input_filter
  import supply_io_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               pin_n_i,
  input  wire logic [WIDTH_W-1:0] width_i,
  output logic                    accept_o
);
  typedef struct packed {
    logic               s1;
    logic               s2;
    logic [WIDTH_W-1:0] cnt;
    logic               fired;
    logic               accept;
  } filt_t;

  filt_t st_q, st_d;
  logic [WIDTH_W-1:0] need;

  always_comb begin
    need = (width_i == '0) ? WIDTH_W'(1) : width_i;
    st_d = st_q;
    st_d.s1 = pin_n_i;
    st_d.s2 = st_q.s1;
    st_d.accept = 1'b0;
    if (st_q.s2) begin
      st_d.cnt = '0;
      st_d.fired = 1'b0;
    end else if (!st_q.fired) begin
      // too-short pulses never reach the count
      if (st_q.cnt + WIDTH_W'(1) >= need) begin
        st_d.accept = 1'b1;
        st_d.fired = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + WIDTH_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, cnt: '0, fired: 1'b0, accept: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign accept_o = st_q.accept;

  AST_ACCEPT_NEEDS_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(accept_o) |-> $past(!st_q.s2))
    else $error("trigger accepted while synchronised input was high");
endmodule
`default_nettype wire

// ==== core/trigger_output_gen.sv ====
// Purpose: drive the trigger output as a pulse or a held level
// Assumes: events are one-cycle pulses on clk_i
// Notes:   a held level stays until release_i
`default_nettype none
module trigger_output_gen
  import supply_io_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               event_i,
  input  wire logic               level_mode_i,
  input  wire logic               level_pol_i,
  input  wire logic [WIDTH_W-1:0] width_i,
  input  wire logic               release_i,
  output logic                    trig_o
);
  typedef struct packed {
    logic [WIDTH_W-1:0] cnt;
    logic               held;
    logic               out;
  } gen_t;

  gen_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (release_i) begin
      st_d.held = 1'b0;
    end
    if (event_i && level_mode_i) begin
      st_d.held = 1'b1;
      st_d.cnt = '0;
    end else if (event_i) begin
      st_d.cnt = (width_i == '0) ? WIDTH_W'(1) : width_i;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - WIDTH_W'(1);
    end
    // rests high unless a pulse runs or a level is held
    if (st_d.held) begin
      st_d.out = level_pol_i;
    end else begin
      st_d.out = (st_d.cnt == '0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= '{cnt: '0, held: 1'b0, out: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign trig_o = st_q.out;

  AST_PULSE_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (event_i && !level_mode_i && width_i == 16'h0003) |=> !trig_o [*3] ##1 (trig_o || st_q.held))
    else $error("trigger pulse width wrong");
endmodule
`default_nettype wire

// ==== tb/trig_far_end.sv ====
// Purpose: far-side equipment that fires the trigger pin
// Assumes: pin rests high through its pull-up between pulses
// Notes:   changes the pin right after a rising edge, like the bench
`default_nettype none
module trig_far_end (
  input  wire logic clk_i,
  output var  logic trigger_input_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial trigger_input_n_o = 1'h1;

  // quiet gap after each pulse so the next trigger is legal
  task automatic send_trigger(input int cycles);
    @(posedge clk_i);
    trigger_input_n_o <= 1'h0;
    repeat (cycles) @(posedge clk_i);
    trigger_input_n_o <= 1'h1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_supply_status_trigger_io.sv ====
// Purpose: self-checking bench of the status flags and trigger paths
// Assumes: pulse widths set small through the config registers
// Notes:   one task per scenario, verdict printed by give_verdict
`default_nettype none
module tb_supply_status_trigger_io
  import supply_io_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_i             = 1'h0;
  logic              rst_b_i           = 1'h0;
  supply_state_t     supply_i          = '0;
  logic              setting_changed_i = 1'h0;
  logic [ADDR_W-1:0] reg_addr_i        = '0;
  logic [DATA_W-1:0] reg_wdata_i       = '0;
  logic              reg_write_i       = 1'h0;
  logic              reg_read_i        = 1'h0;
  wire logic         trig_pin_n;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              output_enable_o;
  trig_cmd_t         trig_cmd_o;
  logic              cv_n, cc_n, alarm_n, powered_n, on_n, trig_o, irq_o;
  int                miscompares = 0;
  int                check_count = 0;
  int                cycles      = 0;

  supply_status_trigger_io dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .supply_i(supply_i),
    .setting_changed_i(setting_changed_i), .trigger_input_n_i(trig_pin_n),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .output_enable_o(output_enable_o), .trig_cmd_o(trig_cmd_o),
    .const_voltage_flag_n_o(cv_n), .const_current_flag_n_o(cc_n),
    .protection_alarm_flag_n_o(alarm_n), .powered_flag_n_o(powered_n),
    .output_on_flag_n_o(on_n), .trigger_output_o(trig_o), .irq_o(irq_o)
  );

  trig_far_end far (.clk_i(clk_i), .trigger_input_n_o(trig_pin_n));

  always #5 clk_i = ~clk_i;

  // hang guard: whole run needs well under 2000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'h1;
    @(posedge clk_i);
    reg_write_i <= 1'h0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'h1;
    @(posedge clk_i);
    reg_read_i <= 1'h0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // first sample is the cycle right after the caller's edge, so a pulse
  // launched by the strobe just taken is counted from its first cycle
  task automatic count_low(input int n, output int lows);
    lows = 0;
    repeat (n) begin
      #1;
      if (trig_o === 1'h0) lows++;
      @(posedge clk_i);
    end
    #1;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk("trigger output idle", 32'h1, trig_o);
    chk("flags after reset", 32'h1f, {cv_n, cc_n, alarm_n, powered_n, on_n});
    chk("irq after reset", 32'h0, irq_o);
    reg_rd(OFS_TRIGGER_INPUT, d);
    chk("trigger_input reset", 32'h0064_0000, d);
    reg_rd(OFS_TRIGGER_OUTPUT, d);
    chk("trigger_output reset", 32'h0064_0001, d);
    reg_rd(8'h3c, d);
    chk("unmapped read", 32'h0, d);
    $display("test reset done");
  endtask

  task automatic t_trigger_output();
    int n;
    int m;
    reg_wr(OFS_TRIGGER_OUTPUT, 32'h0003_0001);
    reg_wr(OFS_CTRL, 32'h1);
    count_low(12, n);
    chk("on event pulse", 32'h3, n);
    chk("rest after pulse", 32'h1, trig_o);
    // level mode, low polarity, setting change only
    reg_wr(OFS_TRIGGER_OUTPUT, 32'h0003_000a);
    reg_wr(OFS_CTRL, 32'h0);
    count_low(12, n);
    chk("unselected event", 32'h0, n);
    @(posedge clk_i);
    setting_changed_i <= 1'h1;
    @(posedge clk_i);
    setting_changed_i <= 1'h0;
    settle(4);
    count_low(8, n);
    chk("held level", 32'h8, n);
    reg_wr(OFS_TRIGGER_OUTPUT, 32'h0003_0001);
    settle(3);
    chk("level released", 32'h1, trig_o);
    // events spaced so the second does not restart the first pulse
    reg_wr(OFS_CTRL, 32'h1);
    count_low(6, n);
    reg_wr(OFS_CTRL, 32'h0);
    count_low(6, m);
    chk("on then off pulses", 32'h6, n + m);
    $display("test trigger output done");
  endtask

  task automatic t_flags();
    logic [31:0] d;
    supply_i.cv_reg  <= 1'h1;
    supply_i.powered <= 1'h1;
    settle(3);
    chk("cv while disabled", 32'h1, cv_n);
    chk("powered flag", 32'h0, powered_n);
    reg_wr(OFS_CTRL, 32'h1);
    settle(3);
    chk("cv flag", 32'h0, cv_n);
    chk("output on flag", 32'h0, on_n);
    supply_i.cv_reg <= 1'h0;
    supply_i.cc_reg <= 1'h1;
    settle(3);
    chk("cv released", 32'h1, cv_n);
    chk("cc flag", 32'h0, cc_n);
    reg_rd(OFS_STATE, d);
    chk("state word", 32'h0000_5000, d);
    for (int i = 0; i < TRIP_W; i++) begin
      supply_i.trips <= 9'h001 << i;
      settle(3);
      chk("alarm on trip", 32'h0, alarm_n);
      supply_i.trips <= 9'h000;
      settle(3);
      chk("alarm cleared", 32'h1, alarm_n);
    end
    reg_wr(OFS_CTRL, 32'h0);
    settle(3);
    chk("cc while disabled", 32'h1, cc_n);
    chk("output off flag", 32'h1, on_n);
    $display("test flags done");
  endtask

  task automatic t_trigger_input();
    int r, v, c;
    reg_wr(OFS_TRIGGER_INPUT, 32'h0004_0000);
    far.send_trigger(2);
    settle(6);
    chk("short pulse ignored", 32'h0, output_enable_o);
    far.send_trigger(8);
    settle(4);
    chk("toggle action", 32'h1, output_enable_o);
    for (int a = 1; a < 4; a++) begin
      r = 0;
      v = 0;
      c = 0;
      reg_wr(OFS_TRIGGER_INPUT, {16'h0004, 8'h00, 4'h5, 2'h0, a[1:0]});
      fork
        far.send_trigger(8);
        repeat (20) begin
          @(posedge clk_i);
          #1;
          if (trig_cmd_o.recall === 1'h1) r++;
          if (trig_cmd_o.apply_v === 1'h1) v++;
          if (trig_cmd_o.apply_c === 1'h1) c++;
        end
      join
      chk("single action", 32'h100 >> (4 * (a - 1)), (r << 8) | (v << 4) | c);
      chk("recall slot", 32'h5, trig_cmd_o.slot);
    end
    $display("test trigger input done");
  endtask

  task automatic t_irq();
    logic [31:0] d;
    reg_wr(OFS_IRQ_STAT, 32'h7);
    reg_rd(OFS_IRQ_STAT, d);
    chk("status cleared", 32'h0, d);
    far.send_trigger(8);
    settle(4);
    reg_rd(OFS_IRQ_STAT, d);
    chk("trigger status", 32'h1, d[0]);
    chk("irq masked", 32'h0, irq_o);
    reg_wr(OFS_IRQ_MASK, 32'h1);
    #1;
    chk("irq unmasked", 32'h1, irq_o);
    reg_wr(OFS_IRQ_STAT, 32'h1);
    #1;
    chk("irq after clear", 32'h0, irq_o);
    $display("test interrupt done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'h1;
    settle(1);
    t_reset();
    t_trigger_output();
    t_flags();
    t_trigger_input();
    t_irq();
    give_verdict();
  end
endmodule
`default_nettype wire
